// file: verilog/suspend_power_and_irq_status.sv
// Suspend power-down control and host interrupt status with an AXI4-Lite slave
// Overview of operation
// - Port-2 overcurrent sensing stays on in suspend when its off bit is 0 and is switched off when it is 1.
// - Port-1 overcurrent sensing stays on in suspend when its off bit is 0 and is switched off when it is 1.
// - The clock-keep bit is bit 0, resets to 0, and while 0 the internal clocks stop on entry to suspend.
// - With clocks gated only the slow suspend oscillator of about 100 kHz keeps running.
// - After a gated suspend the clocks-stable event is raised once all clocks run steadily again.
// - While the clock-keep bit is 1 all internal clocks keep running during suspend.
// - On a 32-bit bus the wake-up counter is 10 us.
// - On a 16-bit bus the wake-up counter is 50 ms.
// - The status register holds dual-role events in bit 10, isochronous completion in bit 9, async in bit 8.
// - Writing 1 to a status bit clears it and writing 0 leaves it alone.
// - Status bits are set by their events regardless of the global interrupt gate.
// - The interrupt output is raised for a status bit only while its enable bit is set.
// - The async status bit is set on a descriptor completion or on a completed mask group.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module suspend_power_and_irq_status
    import susp_irq_pkg::*;
#(
    parameter int WAKE_CYCLES_16BIT = WAKE_CYCLES_16
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Configuration pin and suspend request
    input wire logic busIs16Bit,
    input wire logic suspendReq,
    input wire logic globalIrqGate,
    // Event sources
    input wire logic dualRoleEvent,
    input wire logic isoDescriptorDone,
    input wire logic isoMaskGroupDone,
    input wire logic asyncDescriptorDone,
    input wire logic asyncMaskGroupDone,
    // Overcurrent pins
    input wire logic port1OvercurrentInputN,
    input wire logic port2OvercurrentInputN,
    // Power and clock control
    output logic port1OvercurrentSenseOn,
    output logic port2OvercurrentSenseOn,
    output logic port1Overcurrent,
    output logic port2Overcurrent,
    output logic internalClocksRun,
    output logic slowSuspendOscillatorRun,
    output logic inSuspend,
    output logic irq
);

    // --------------------------------------------------------------
    // Register state
    // --------------------------------------------------------------
    logic [31:0] powerDownCtrl, next_powerDownCtrl;
    logic [31:0] irqStatus, next_irqStatus;
    logic [31:0] irqEnable, next_irqEnable;

    logic awHeld, next_awHeld, wHeld, next_wHeld;
    logic [ADDR_W-1:0] awAddrQ, next_awAddrQ;
    logic [DATA_W-1:0] wDataQ, next_wDataQ;
    logic [3:0] wStrbQ, next_wStrbQ;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [DATA_W-1:0] next_rdata;

    logic commitWrite, writeHit;
    logic [ADDR_W-1:0] wordAddrW, wordAddrR;
    logic [31:0] laneMask, writeBits, clearVec, setVec;

    // --------------------------------------------------------------
    // Synchronisers for pins
    // --------------------------------------------------------------
    logic [2:0] pinMeta, pinSync, pinRaw;
    logic bus16;
    logic [1:0] ocSenseOff, ocSenseOn, ocFlag, next_ocFlag;

    // --------------------------------------------------------------
    // Power state
    // --------------------------------------------------------------
    pwr_state_t pwrState, next_pwrState;
    logic wakeStart, wakeDone, clocksStableEvent, asyncListDone, isoListDone;
    logic [WAKE_CNT_W-1:0] wakeLoad;

    // --------------------------------------------------------------
    // Pin synchronisation
    // --------------------------------------------------------------
    assign pinRaw = {busIs16Bit, port2OvercurrentInputN, port1OvercurrentInputN};
    // Overcurrent pins reset to their idle high level so no false fault follows reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pinMeta <= 3'h3;
            pinSync <= 3'h3;
        end else begin
            pinMeta <= pinRaw;
            pinSync <= pinMeta;
        end
    end
    assign bus16 = pinSync[2];

    // --------------------------------------------------------------
    // Overcurrent sensing per port
    // --------------------------------------------------------------
    assign ocSenseOff = {powerDownCtrl[OC2_OFF_BIT], powerDownCtrl[OC1_OFF_BIT]};
    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++) begin : g_port
            // Sensing drops only while suspended; in normal running it always stays powered
            assign ocSenseOn[gp] = !(inSuspend && ocSenseOff[gp]);
            assign next_ocFlag[gp] = ocSenseOn[gp] && !pinSync[gp];
        end
    endgenerate
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ocFlag <= 2'h0;
        end else begin
            ocFlag <= next_ocFlag;
        end
    end
    assign port1OvercurrentSenseOn = ocSenseOn[0];
    assign port2OvercurrentSenseOn = ocSenseOn[1];
    assign port1Overcurrent = ocFlag[0];
    assign port2Overcurrent = ocFlag[1];

    // --------------------------------------------------------------
    // Suspend and clock control
    // --------------------------------------------------------------
    // Strap is read through the synchroniser, so a change takes effect on the next wake only
    assign wakeLoad = bus16 ? WAKE_CNT_W'(WAKE_CYCLES_16BIT) : WAKE_CNT_W'(WAKE_CYCLES_32);
    always_comb begin
        next_pwrState = pwrState;
        wakeStart = 1'b0;
        case (pwrState)
            PS_RUN: begin
                if (suspendReq) begin
                    next_pwrState = powerDownCtrl[CLK_KEEP_BIT] ? PS_SUSP_CLK_ON : PS_GATED;
                end
            end
            PS_SUSP_CLK_ON: next_pwrState = suspendReq ? PS_SUSP_CLK_ON : PS_RUN;
            PS_GATED: begin
                if (!suspendReq) begin
                    next_pwrState = PS_WAKING;
                    wakeStart = 1'b1;
                end
            end
            PS_WAKING: next_pwrState = wakeDone ? PS_RUN : PS_WAKING;
            default: next_pwrState = PS_RUN;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pwrState <= PS_RUN;
        end else begin
            pwrState <= next_pwrState;
        end
    end

    wake_timer u_wake_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(wakeStart),
        .loadCycles(wakeLoad),
        .busy(),
        .done(wakeDone)
    );

    assign clocksStableEvent = wakeDone;
    assign internalClocksRun = (pwrState != PS_GATED);
    assign slowSuspendOscillatorRun = 1'b1;
    assign inSuspend = (pwrState == PS_GATED) || (pwrState == PS_SUSP_CLK_ON);

    // --------------------------------------------------------------
    // AXI4-Lite write channel
    // --------------------------------------------------------------
    assign awready = !awHeld;
    assign wready = !wHeld;
    assign commitWrite = awHeld && wHeld && !bvalid;
    assign wordAddrW = {awAddrQ[ADDR_W-1:2], 2'h0};
    assign laneMask = {{8{wStrbQ[3]}}, {8{wStrbQ[2]}}, {8{wStrbQ[1]}}, {8{wStrbQ[0]}}};
    assign writeBits = wDataQ & laneMask;
    assign writeHit = (wordAddrW == PWR_CTRL_OFFSET) || (wordAddrW == IRQ_STATUS_OFFSET) ||
                      (wordAddrW == IRQ_ENABLE_OFFSET) || (wordAddrW == IRQ_CLEAR_OFFSET);

    always_comb begin
        next_awHeld = awHeld;
        next_awAddrQ = awAddrQ;
        next_wHeld = wHeld;
        next_wDataQ = wDataQ;
        next_wStrbQ = wStrbQ;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (commitWrite) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = writeHit ? RESP_OKAY : RESP_SLVERR;
        end
        if (awvalid && awready) begin
            next_awHeld = 1'b1;
            next_awAddrQ = awaddr;
        end
        if (wvalid && wready) begin
            next_wHeld = 1'b1;
            next_wDataQ = wdata;
            next_wStrbQ = wstrb;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            awHeld <= 1'b0;
            awAddrQ <= '0;
            wHeld <= 1'b0;
            wDataQ <= '0;
            wStrbQ <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            awHeld <= next_awHeld;
            awAddrQ <= next_awAddrQ;
            wHeld <= next_wHeld;
            wDataQ <= next_wDataQ;
            wStrbQ <= next_wStrbQ;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
        end
    end

    // --------------------------------------------------------------
    // Register updates
    // --------------------------------------------------------------
    assign asyncListDone = asyncDescriptorDone || asyncMaskGroupDone;
    assign isoListDone = isoDescriptorDone || isoMaskGroupDone;
    always_comb begin
        setVec = 32'h0000_0000;
        setVec[DUAL_ROLE_BIT] = dualRoleEvent;
        setVec[ISO_DONE_BIT] = isoListDone;
        setVec[ASYNC_DONE_BIT] = asyncListDone;
        setVec[CLK_STABLE_BIT] = clocksStableEvent;
    end

    // Status and clear offsets share one write-one-to-clear path
    assign clearVec = (commitWrite && ((wordAddrW == IRQ_STATUS_OFFSET) || (wordAddrW == IRQ_CLEAR_OFFSET))) ?
                      writeBits : 32'h0000_0000;

    always_comb begin
        next_powerDownCtrl = powerDownCtrl;
        next_irqEnable = irqEnable;
        if (commitWrite && (wordAddrW == PWR_CTRL_OFFSET)) begin
            next_powerDownCtrl = ((powerDownCtrl & ~laneMask) | writeBits) & PWR_CTRL_IMPL_MASK;
        end
        if (commitWrite && (wordAddrW == IRQ_ENABLE_OFFSET)) begin
            next_irqEnable = ((irqEnable & ~laneMask) | writeBits) & STATUS_IMPL_MASK;
        end
        // A set arriving with its clear wins; the global gate plays no part here
        next_irqStatus = ((irqStatus & ~clearVec) | setVec) & STATUS_IMPL_MASK;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            powerDownCtrl <= PWR_CTRL_RESET;
            irqStatus <= STATUS_RESET;
            irqEnable <= ENABLE_RESET;
        end else begin
            powerDownCtrl <= next_powerDownCtrl;
            irqStatus <= next_irqStatus;
            irqEnable <= next_irqEnable;
        end
    end

    // Level output; the gate masks the line only, never the status
    assign irq = globalIrqGate && |(irqStatus & irqEnable);

    // --------------------------------------------------------------
    // AXI4-Lite read channel
    // --------------------------------------------------------------
    assign arready = !rvalid;
    assign wordAddrR = {araddr[ADDR_W-1:2], 2'h0};

    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            // Read-back of the full control word supports the 16-bit restore sequence
            case (wordAddrR)
                PWR_CTRL_OFFSET: next_rdata = powerDownCtrl;
                IRQ_STATUS_OFFSET: next_rdata = irqStatus;
                IRQ_ENABLE_OFFSET: next_rdata = irqEnable;
                IRQ_CLEAR_OFFSET: next_rdata = 32'h0000_0000;
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

endmodule

// file: shared/susp_irq_pkg.sv
// Constants and types shared by the suspend power and interrupt status block
package susp_irq_pkg;

    // --------------------------------------------------------------
    // Bus shape
    // --------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // --------------------------------------------------------------
    // Register offsets (byte addresses)
    // --------------------------------------------------------------
    localparam logic [15:0] IRQ_STATUS_OFFSET = 16'h0310;
    localparam logic [15:0] IRQ_ENABLE_OFFSET = 16'h0314;
    localparam logic [15:0] IRQ_CLEAR_OFFSET = 16'h0318;
    localparam logic [15:0] PWR_CTRL_OFFSET = 16'h0354;

    // --------------------------------------------------------------
    // Field positions, masks and reset values
    // --------------------------------------------------------------
    localparam int CLK_KEEP_BIT = 0;
    localparam int OC1_OFF_BIT = 1;
    localparam int OC2_OFF_BIT = 2;
    localparam logic [31:0] PWR_CTRL_IMPL_MASK = 32'h0000_0007;
    localparam logic [31:0] PWR_CTRL_RESET = 32'h0000_0000;

    localparam int CLK_STABLE_BIT = 6;
    localparam int ASYNC_DONE_BIT = 8;
    localparam int ISO_DONE_BIT = 9;
    localparam int DUAL_ROLE_BIT = 10;
    localparam logic [31:0] STATUS_IMPL_MASK = 32'h0000_0740;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int WAKE_TIME_32_US = 10;
    localparam int WAKE_TIME_16_MS = 50;
    localparam int WAKE_CYCLES_32 = (WAKE_TIME_32_US * 1000) / CLK_PERIOD_NS;
    localparam int WAKE_CYCLES_16 = (WAKE_TIME_16_MS * 1000000) / CLK_PERIOD_NS;
    localparam int WAKE_CNT_W = 23;

    // --------------------------------------------------------------
    // Power state machine
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        PS_RUN,
        PS_SUSP_CLK_ON,
        PS_GATED,
        PS_WAKING
    } pwr_state_t;

endpackage

// file: verilog/wake_timer.sv
// Down-counter that times the clock restart after a gated suspend
`timescale 1ns/1ps
module wake_timer
    import susp_irq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [WAKE_CNT_W-1:0] loadCycles,
    output logic busy,
    output logic done
);

    logic [WAKE_CNT_W-1:0] count;
    logic [WAKE_CNT_W-1:0] next_count;
    logic next_busy;
    logic next_done;

    // --------------------------------------------------------------
    // Counting
    // --------------------------------------------------------------
    always_comb begin
        next_count = count;
        next_busy = busy;
        next_done = 1'b0;
        if (start) begin
            next_count = loadCycles;
            next_busy = 1'b1;
        end else if (busy) begin
            if (count <= {{(WAKE_CNT_W-1){1'b0}}, 1'b1}) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else begin
                next_count = count - {{(WAKE_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            count <= next_count;
            busy <= next_busy;
            done <= next_done;
        end
    end

endmodule

// file: testbench/susp_irq_properties.sv
// Port-level checker for the suspend power and interrupt status block
`timescale 1ns/1ps
module susp_irq_properties
    import susp_irq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic suspendReq,
    input wire logic globalIrqGate,
    input wire logic port1OvercurrentSenseOn,
    input wire logic port2OvercurrentSenseOn,
    input wire logic port1Overcurrent,
    input wire logic internalClocksRun,
    input wire logic slowSuspendOscillatorRun,
    input wire logic inSuspend,
    input wire logic irq
);
    // ------
    // Properties
    // ------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_sense_one_on: assert property (!inSuspend |-> port1OvercurrentSenseOn)
        else $error("port 1 sensing off outside suspend");
    a_sense_two_on: assert property (!inSuspend |-> port2OvercurrentSenseOn)
        else $error("port 2 sensing off outside suspend");
    a_oc_quiet: assert property (!port1OvercurrentSenseOn && !$past(port1OvercurrentSenseOn) |-> !port1Overcurrent)
        else $error("port 1 overcurrent flagged while sensing off");
    a_gated_stays: assert property (!internalClocksRun && suspendReq |=> !internalClocksRun)
        else $error("clocks restarted during suspend");
    a_gated_suspend: assert property (!internalClocksRun |-> inSuspend && slowSuspendOscillatorRun)
        else $error("clocks stopped outside suspend or slow oscillator off");
    a_irq_gate: assert property (!globalIrqGate |-> !irq)
        else $error("irq high with global gate closed");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read data not returned next cycle");
    a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer dropped or changed");
    a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped or changed");
endmodule

bind suspend_power_and_irq_status susp_irq_properties i_props (.ref_clk, .rst_n, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .bresp, .bvalid, .bready, .suspendReq, .globalIrqGate, .port1OvercurrentSenseOn,
    .port2OvercurrentSenseOn, .port1Overcurrent, .internalClocksRun, .slowSuspendOscillatorRun, .inSuspend, .irq);

// file: testbench/host_bus_model.sv
// Host processor model: AXI4-Lite master plus driver start-up habits
`timescale 1ns/1ps
module host_bus_model
    import susp_irq_pkg::*;
(
    input wire logic ref_clk,
    output logic [ADDR_W-1:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [DATA_W-1:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [ADDR_W-1:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    end

    // ------
    // Bus cycles; ready trails the answer by a cycle so the slave must hold it
    // ------
    task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        logic done;
        @(posedge ref_clk);
        {awaddr, wdata, wstrb} <= {a, d, 4'hF};
        {awvalid, wvalid} <= 2'h3;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            done = bvalid && bready;
            bready <= bvalid && !bready;
        end while (!done);
        r = bresp;
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
            done = rvalid && rready;
            rready <= rvalid && !rready;
        end while (!done);
        {d, r} = {rdata, rresp};
    endtask

    task automatic init_power(input logic is16);
        logic [31:0] v;
        logic [1:0] r;
        if (is16) begin
            rd(PWR_CTRL_OFFSET, v, r);
            wr(PWR_CTRL_OFFSET, v, r);
        end
    endtask

    // Stale status would fire the moment enables open
    task automatic arm_irqs(input logic [31:0] en);
        logic [1:0] r;
        wr(IRQ_STATUS_OFFSET, 32'hFFFF_FFFF, r);
        wr(IRQ_ENABLE_OFFSET, en, r);
    endtask
endmodule

// file: testbench/suspend_power_and_irq_status_tb_top.sv
// Self-checking bench for the suspend power and interrupt status block
`timescale 1ns/1ps
module suspend_power_and_irq_status_tb_top
    import susp_irq_pkg::*;
;
    localparam int WAKE_SHORT = 20;
    localparam logic [31:0] EV_BIT [5] = '{32'h0000_0400, 32'h0000_0200, 32'h0000_0200, 32'h0000_0100, 32'h0000_0100};
    logic ref_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic busIs16Bit, suspendReq, globalIrqGate, port1OvercurrentInputN, port2OvercurrentInputN;
    logic port1OvercurrentSenseOn, port2OvercurrentSenseOn, port1Overcurrent, port2Overcurrent;
    logic internalClocksRun, slowSuspendOscillatorRun, inSuspend, irq;
    logic [4:0] ev;
    int miscompares, nCompared, stModel, enModel;

    suspend_power_and_irq_status #(.WAKE_CYCLES_16BIT(WAKE_SHORT)) i_dut (.ref_clk, .rst_n, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .busIs16Bit, .suspendReq, .globalIrqGate, .dualRoleEvent(ev[0]),
        .isoDescriptorDone(ev[1]), .isoMaskGroupDone(ev[2]), .asyncDescriptorDone(ev[3]),
        .asyncMaskGroupDone(ev[4]), .port1OvercurrentInputN, .port2OvercurrentInputN, .port1OvercurrentSenseOn,
        .port2OvercurrentSenseOn, .port1Overcurrent, .port2Overcurrent, .internalClocksRun,
        .slowSuspendOscillatorRun, .inSuspend, .irq);

    host_bus_model i_host (.ref_clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

    // ------
    // Checking helpers
    // ------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("compared %0d mismatched %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic rd_check(input string what, input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        i_host.rd(a, d, r);
        check(what, d, e);
        check("resp", r, er);
    endtask

    task automatic pulse(input int k);
        @(posedge ref_clk);
        ev <= 5'h01 << k;
        @(posedge ref_clk);
        ev <= 5'h00;
        stModel |= EV_BIT[k];
        @(negedge ref_clk);
        check("irq", irq, globalIrqGate && (stModel & enModel) != 0);
    endtask

    task automatic suspend_run(input logic [31:0] p, input logic is16, input int n);
        logic [1:0] r;
        int cnt;
        busIs16Bit <= is16;
        i_host.wr(PWR_CTRL_OFFSET, p, r);
        i_host.init_power(is16);
        i_host.arm_irqs(32'h0000_0040);
        enModel = 32'h40;
        stModel = 0;
        suspendReq <= 1'b1;
        port1OvercurrentInputN <= 1'b0;
        port2OvercurrentInputN <= 1'b0;
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        check("in suspend", inSuspend, 1);
        check("clocks run", internalClocksRun, p[0]);
        check("slow osc", slowSuspendOscillatorRun, 1);
        check("sense 1", port1OvercurrentSenseOn, !p[1]);
        check("sense 2", port2OvercurrentSenseOn, !p[2]);
        check("oc 1", port1Overcurrent, !p[1]);
        check("oc 2", port2Overcurrent, !p[2]);
        @(posedge ref_clk);
        suspendReq <= 1'b0;
        port1OvercurrentInputN <= 1'b1;
        port2OvercurrentInputN <= 1'b1;
        cnt = 0;
        // Keep-clock suspend must never raise the event, so that wait runs to its limit
        while (!irq && cnt < n + 10) begin
            @(negedge ref_clk);
            cnt++;
        end
        if (p[0]) check("no clock event", irq, 0);
        else check("wake time", cnt >= n && cnt <= n + 5, 1);
        rd_check("status", IRQ_STATUS_OFFSET, p[0] ? 0 : 32'h40, RESP_OKAY);
    endtask

    // ------
    // Clock, watchdog and scenarios
    // ------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Full run is near 4100 cycles; over fourteen times that is ample
    initial begin
        #480000;
        miscompares++;
        stop_test();
    end

    initial begin
        logic [1:0] r;
        logic [31:0] v;
        {rst_n, busIs16Bit, suspendReq, globalIrqGate, ev} = '0;
        {port1OvercurrentInputN, port2OvercurrentInputN} = 2'h3;
        {miscompares, nCompared, stModel, enModel} = '0;
        void'($urandom(32'h052E));
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_check("status", IRQ_STATUS_OFFSET, STATUS_RESET, RESP_OKAY);
        rd_check("enable", IRQ_ENABLE_OFFSET, ENABLE_RESET, RESP_OKAY);
        rd_check("power", PWR_CTRL_OFFSET, PWR_CTRL_RESET, RESP_OKAY);
        rd_check("unmapped", 16'h0400, 0, RESP_SLVERR);
        i_host.wr(16'h0400, 32'hFFFF_FFFF, r);
        check("unmapped wr", r, RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            i_host.wr(PWR_CTRL_OFFSET, v, r);
            rd_check("power", PWR_CTRL_OFFSET, v & PWR_CTRL_IMPL_MASK, RESP_OKAY);
        end
        i_host.arm_irqs(32'h0000_0100);
        enModel = 32'h100;
        stModel = 0;
        for (int k = 0; k < 5; k++) begin
            pulse(k);
            rd_check("status", IRQ_STATUS_OFFSET, stModel, RESP_OKAY);
            i_host.wr(IRQ_STATUS_OFFSET, 32'h0, r);
            rd_check("status", IRQ_STATUS_OFFSET, stModel, RESP_OKAY);
            v = $urandom;
            i_host.wr(IRQ_STATUS_OFFSET, stModel | (v & ~STATUS_IMPL_MASK), r);
            stModel = 0;
            rd_check("status", IRQ_STATUS_OFFSET, stModel, RESP_OKAY);
        end
        globalIrqGate <= 1'b1;
        pulse(2);
        pulse(4);
        i_host.wr(IRQ_CLEAR_OFFSET, 32'h0000_0100, r);
        stModel &= ~32'h100;
        check("irq", irq, 0);
        rd_check("status", IRQ_STATUS_OFFSET, stModel, RESP_OKAY);
        suspend_run(32'h6, 1'b0, WAKE_CYCLES_32);
        suspend_run(32'h0, 1'b1, WAKE_SHORT);
        suspend_run(32'h1, 1'b0, WAKE_CYCLES_32);
        suspend_run(32'h3, 1'b0, WAKE_CYCLES_32);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_check("power", PWR_CTRL_OFFSET, PWR_CTRL_RESET, RESP_OKAY);
        stop_test();
    end
endmodule
